// >>> hdl/pesi_defines.vh
// Purpose: constants for the pcs error and skew injector
// Assumes: included by hdl/pesi_injector.v only
// Notes: definitions only
`ifndef PESI_DEFINES_VH
`define PESI_DEFINES_VH
// insertion modes
`define PESI_MODE_OFF 3'h0
`define PESI_MODE_MANUAL 3'h1
`define PESI_MODE_BURST 3'h2
`define PESI_MODE_RATE 3'h3
`define PESI_MODE_ALT 3'h4
`define PESI_MODE_ALL 3'h5
// error destinations
`define PESI_DST_BLKTYPE 2'h0
`define PESI_DST_SYNCHDR 2'h1
`define PESI_DST_AMARK 2'h2
`define PESI_DST_BIP 2'h3
// block field positions within a 66-bit block
`define PESI_SH_LSB 0
`define PESI_BT_LSB 2
`define PESI_BIP_LSB 34
// corruption values
`define PESI_BAD_SH 2'h3
`define PESI_BAD_BT 8'h00
`define PESI_AM_FLIP 8'hFF
// frequency deviation accumulator
`define PESI_PHASE_W 24
`define PESI_PHASE_NOM 24'h400000
`endif

// >>> hdl/pesi_injector.v
// Contract
// - mode off adds no pcs errors; wan errors follow wan_err_mode and port_is_wan10g, not ins_mode
// - manual trigger inserts exactly configured error count
// - burst inserts configured count then stops
// - rate mode inserts continuously at configured rate
// - alternate repeats insertion once per frame interval
// - all mode corrupts every transmitted frame
// - pcs errors only on masked lanes
// - invalid block type uses undefined type value
// - invalid sync header uses undefined pattern
// - invalid marker departs from standard marker
// - bip error corrupts marker parity field
// - skew delays selected lanes by bit count
// - skew zero keeps all lanes aligned
// - 100g lane type selects skew mask grouping
// - wan insertion only in 10g wan mode
// - alarms stay asserted while enabled: pcs alarm outside mode off, wan alarm only on a 10g wan port
// - wan manual count from wan burst length
// - signed deviation raises or lowers tx rate
//
// Purpose: transmit-side pcs error, skew, wan and frequency impairment injector
// Assumes: one 66-bit block per lane per blk_valid cycle; single clock
// Notes: all outputs registered; skew shift applies up to MAX_SKEW bits, larger skew_bits give no shift
`timescale 1ns/1ns
`include "pesi_defines.vh"
module pesi_injector #(
  parameter LANES = 4,
  parameter BLK_W = 66,
  parameter CNT_W = 16,
  parameter MAX_SKEW = 64,
  parameter SKEW_W = 7
) (
  // clock and reset
  input wire core_clk,
  input wire resetn,
  // transmit block stream
  input wire blk_valid,
  input wire [LANES*BLK_W-1:0] blk_data,
  input wire [LANES-1:0] blk_is_am,
  input wire frame_end,
  output reg out_valid_r,
  output reg [LANES*BLK_W-1:0] out_data_r,
  // pcs error control
  input wire err_alarm_sel,
  input wire [1:0] err_dest,
  input wire [2:0] ins_mode,
  input wire [CNT_W-1:0] burst_len,
  input wire [CNT_W-1:0] rate_period,
  input wire [CNT_W-1:0] alt_frames,
  input wire err_trigger,
  input wire [LANES-1:0] err_lane_mask,
  // skew control
  input wire [SKEW_W-1:0] skew_bits,
  input wire [LANES-1:0] skew_lane_mask,
  input wire port_is_100g,
  input wire lane_type_phys,
  // wan control
  input wire port_is_wan10g,
  input wire wan_alarm_en,
  input wire wan_err_mode,
  input wire [CNT_W-1:0] wan_burst_len,
  input wire wan_trigger,
  output reg wan_alarm_r,
  output reg wan_err_r,
  // frequency deviation
  input wire [15:0] tx_deviation,
  output reg tx_rate_tick_r,
  // status
  output reg err_active_r
);
  // ****************************************
  // mode latch and counters
  // ****************************************
  reg [2:0] mode_r;
  reg [CNT_W-1:0] remain_r;
  reg [CNT_W-1:0] period_r;
  reg [CNT_W-1:0] wan_remain_r;
  reg ins_now;
  reg [CNT_W-1:0] remain_nxt;
  reg [CNT_W-1:0] period_nxt;

  always @* begin
    ins_now = 1'b0;
    remain_nxt = remain_r;
    period_nxt = period_r;
    case (mode_r)
      `PESI_MODE_OFF: begin
        remain_nxt = {CNT_W{1'b0}};
      end
      `PESI_MODE_MANUAL, `PESI_MODE_BURST: begin
        ins_now = (remain_r != {CNT_W{1'b0}});
        if (ins_now) begin
          remain_nxt = remain_r - 1'b1;
        end
      end
      `PESI_MODE_RATE: begin
        ins_now = (remain_r != {CNT_W{1'b0}});
        if (ins_now) begin
          remain_nxt = remain_r - 1'b1;
        end
        if (period_r >= rate_period) begin
          period_nxt = {CNT_W{1'b0}};
          remain_nxt = burst_len;
        end else begin
          period_nxt = period_r + 1'b1;
        end
      end
      `PESI_MODE_ALT: begin
        ins_now = (remain_r != {CNT_W{1'b0}});
        if (ins_now) begin
          remain_nxt = remain_r - 1'b1;
        end
      end
      `PESI_MODE_ALL: begin
        ins_now = 1'b1;
      end
      default: begin
        ins_now = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (!resetn) begin
      mode_r <= `PESI_MODE_OFF;
      remain_r <= {CNT_W{1'b0}};
      period_r <= {CNT_W{1'b0}};
    end else begin
      if (blk_valid) begin
        remain_r <= remain_nxt;
        period_r <= period_nxt;
        if (mode_r != ins_mode) begin
          // new mode at block boundary, counters restart clean
          mode_r <= ins_mode;
          remain_r <= (ins_mode == `PESI_MODE_BURST) ? burst_len : {CNT_W{1'b0}};
          period_r <= {CNT_W{1'b0}};
        end else if (mode_r == `PESI_MODE_ALT && frame_end) begin
          if (period_r + 1'b1 >= alt_frames) begin
            period_r <= {CNT_W{1'b0}};
            remain_r <= burst_len;
          end else begin
            period_r <= period_r + 1'b1;
          end
        end
      end
      // trigger honoured only in manual mode and when idle
      if (err_trigger && mode_r == `PESI_MODE_MANUAL && ins_mode == `PESI_MODE_MANUAL
          && remain_r == {CNT_W{1'b0}}) begin
        remain_r <= burst_len;
      end
    end
  end

  // ****************************************
  // pcs corruption per lane
  // ****************************************
  // lane type on 100g swaps skew mask to the other grouping order
  wire use_rev = port_is_100g & lane_type_phys;
  wire [LANES*BLK_W-1:0] corr_data;
  wire [LANES*BLK_W-1:0] skew_data;
  wire [LANES-1:0] err_mask_eff;
  wire [LANES-1:0] skew_mask_eff;

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      wire [BLK_W-1:0] din = blk_data[g*BLK_W +: BLK_W];
      reg [BLK_W-1:0] dout;
      reg [MAX_SKEW-1:0] hist_r;
      assign err_mask_eff[g] = err_lane_mask[g];
      assign skew_mask_eff[g] = use_rev ? skew_lane_mask[LANES-1-g] : skew_lane_mask[g];
      always @* begin
        dout = din;
        if (ins_now && !err_alarm_sel && err_mask_eff[g]) begin
          case (err_dest)
            `PESI_DST_BLKTYPE: dout[`PESI_BT_LSB +: 8] = `PESI_BAD_BT;
            `PESI_DST_SYNCHDR: dout[`PESI_SH_LSB +: 2] = `PESI_BAD_SH;
            `PESI_DST_AMARK: if (blk_is_am[g]) dout[`PESI_BT_LSB +: 8] = din[`PESI_BT_LSB +: 8] ^ `PESI_AM_FLIP;
            `PESI_DST_BIP: if (blk_is_am[g]) dout[`PESI_BIP_LSB +: 8] = ~din[`PESI_BIP_LSB +: 8];
            default: dout = din;
          endcase
        end
        if (err_alarm_sel && mode_r != `PESI_MODE_OFF && err_mask_eff[g]) begin
          // alarm: held invalid sync header while enabled
          dout[`PESI_SH_LSB +: 2] = `PESI_BAD_SH;
        end
      end
      assign corr_data[g*BLK_W +: BLK_W] = dout;
      // bit history of the lane, latest bits at the top
      always @(posedge core_clk) begin
        if (!resetn) begin
          hist_r <= {MAX_SKEW{1'b0}};
        end else if (blk_valid) begin
          hist_r <= dout[BLK_W-1 -: MAX_SKEW];
        end
      end
      // delay by skew_bits: shift history bits into the block
      wire [BLK_W+MAX_SKEW-1:0] cat = {dout, hist_r};
      wire [SKEW_W-1:0] sh = (skew_mask_eff[g] && skew_bits <= MAX_SKEW) ? skew_bits : {SKEW_W{1'b0}};
      assign skew_data[g*BLK_W +: BLK_W] = cat[MAX_SKEW - sh +: BLK_W];
    end
  endgenerate

  // ****************************************
  // wan alarm and error insertion
  // ****************************************
  always @(posedge core_clk) begin
    if (!resetn) begin
      wan_remain_r <= {CNT_W{1'b0}};
      wan_err_r <= 1'b0;
      wan_alarm_r <= 1'b0;
    end else begin
      wan_alarm_r <= port_is_wan10g & wan_alarm_en;
      wan_err_r <= 1'b0;
      if (!port_is_wan10g || !wan_err_mode) begin
        wan_remain_r <= {CNT_W{1'b0}};
      end else if (wan_trigger && wan_remain_r == {CNT_W{1'b0}}) begin
        wan_remain_r <= wan_burst_len;
      end else if (blk_valid && wan_remain_r != {CNT_W{1'b0}}) begin
        wan_remain_r <= wan_remain_r - 1'b1;
        wan_err_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // output stage and rate generator
  // ****************************************
  reg [`PESI_PHASE_W-1:0] phase_r;
  // sign-extended deviation added to nominal increment
  wire [`PESI_PHASE_W-1:0] phase_inc = `PESI_PHASE_NOM + {{(`PESI_PHASE_W-16){tx_deviation[15]}}, tx_deviation};
  wire [`PESI_PHASE_W:0] phase_sum = {1'b0, phase_r} + {1'b0, phase_inc};

  always @(posedge core_clk) begin
    if (!resetn) begin
      out_valid_r <= 1'b0;
      out_data_r <= {LANES*BLK_W{1'b0}};
      err_active_r <= 1'b0;
      phase_r <= {`PESI_PHASE_W{1'b0}};
      tx_rate_tick_r <= 1'b0;
    end else begin
      out_valid_r <= blk_valid;
      if (blk_valid) begin
        out_data_r <= skew_data;
      end
      err_active_r <= blk_valid & ins_now & ~err_alarm_sel;
      phase_r <= phase_sum[`PESI_PHASE_W-1:0];
      tx_rate_tick_r <= phase_sum[`PESI_PHASE_W];
    end
  end
endmodule // pesi_injector

// >>> test/pesi_injector_bench.sv
// Purpose: self-checking bench for the injector
// Assumes: lane0 selected, lane3 selected only for skew through the reversed 100g mask
// Notes: pcs error counts come from the far-end model
`timescale 1ns/1ns
module pesi_injector_bench;
  reg core_clk = 0, resetn = 0, blk_valid = 0, err_alarm_sel = 0, err_trigger = 0, wan_alarm_en = 0;
  reg port_is_wan10g = 0, wan_err_mode = 0, wan_trigger = 0;
  reg [263:0] blk_data = 0;
  reg [1:0] err_dest = 0;
  reg [2:0] ins_mode = 0;
  reg [15:0] burst_len = 16'h3, rate_period = 16'h3, wan_burst_len = 16'h2, tx_deviation = 0, b0, b3;
  reg [3:0] err_lane_mask = 4'h1, skew_lane_mask = 4'h1;
  reg [6:0] skew_bits = 0;
  reg [3:0] blk_is_am = 0;
  reg frame_end = 0, port_is_100g = 0, lane_type_phys = 0;
  reg [15:0] alt_frames = 0;
  reg [55:0] k = 0;
  wire out_valid_r, wan_alarm_r, wan_err_r, tx_rate_tick_r, err_active_r;
  wire [263:0] out_data_r;
  wire [15:0] bad0, bad3;
  int n_fail = 0, samples_checked = 0, wn = 0, tk = 0, w0, c0, c1;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    wn <= wn + (wan_err_r === 1'b1);
    tk <= tk + (tx_rate_tick_r === 1'b1);
  end
  pesi_injector dut(.*);
  pesi_rx_model m(.core_clk(core_clk), .vld(out_valid_r), .data(out_data_r), .bad0(bad0), .bad3(bad3));
  task chk(input string s, input [65:0] e, g);
    samples_checked++;
    if (e !== g) begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", s, e, g);
    end
  endtask
  task tick(int n);
    repeat (n) @(posedge core_clk) #1;
  endtask
  task send(int n);
    repeat (n) begin
      blk_valid = 1;
      blk_data = {4{k, 8'h1E, 2'h2}};
      k = k + 1;
      tick(1);
    end
    blk_valid = 0;
  endtask
  // one latching block first, since the old mode still owns it
  task go(input [2:0] md);
    ins_mode = md;
    send(1);
    tick(2);
    b0 = bad0;
    b3 = bad3;
  endtask
  task bad(input [15:0] e0, e3);
    tick(3);
    chk("lane0 errors", e0, bad0 - b0);
    chk("lane3 errors", e3, bad3 - b3);
  endtask
  task trig;
    err_trigger = 1;
    tick(1);
    err_trigger = 0;
  endtask
  task rate(input [15:0] d, output int c);
    tx_deviation = d;
    tick(4);
    c = tk;
    tick(2048);
    c = tk - c;
  endtask
  task results;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    tick(3);
    resetn = 1;
    skew_bits = 1;
    k = 56'h80000000000000;
    send(2);
    chk("skewed lane", {55'h1, 8'h1E, 2'h2, 1'b1}, out_data_r[65:0]);
    chk("plain lane", {56'h80000000000001, 8'h1E, 2'h2}, out_data_r[263:198]);
    port_is_100g = 1;
    lane_type_phys = 1;
    tick(1);
    send(1);
    chk("reversed lane", {55'h2, 8'h1E, 2'h2, 1'b1}, out_data_r[263:198]);
    chk("reversed plain", {56'h80000000000002, 8'h1E, 2'h2}, out_data_r[65:0]);
    chk("error flag idle", 0, err_active_r);
    port_is_100g = 0;
    lane_type_phys = 0;
    skew_bits = 0;
    err_dest = 1;
    go(0);
    trig;
    send(4);
    bad(0, 0);
    go(1);
    trig;
    send(6);
    bad(3, 0);
    burst_len = 2;
    go(2);
    trig;
    send(6);
    bad(2, 0);
    err_dest = 0;
    go(5);
    send(8);
    bad(8, 0);
    err_dest = 1;
    send(4);
    bad(12, 0);
    err_dest = 2;
    tick(1);
    send(1);
    chk("plain not marker", 8'h1E, out_data_r[9:2]);
    chk("error flag", 1, err_active_r);
    blk_is_am = 4'h1;
    tick(1);
    send(1);
    chk("marker type", 8'hE1, out_data_r[9:2]);
    err_dest = 3;
    tick(1);
    send(1);
    chk("marker parity", {58'h0, ~blk_data[41:34]}, out_data_r[41:34]);
    blk_is_am = 0;
    err_alarm_sel = 1;
    err_dest = 0;
    tick(1);
    send(1);
    chk("alarm header", 2'h3, out_data_r[1:0]);
    chk("alarm flag", 0, err_active_r);
    err_alarm_sel = 0;
    err_dest = 1;
    tick(1);
    burst_len = 1;
    go(3);
    send(16);
    bad(3, 0);
    alt_frames = 2;
    go(4);
    frame_end = 1;
    send(9);
    frame_end = 0;
    bad(4, 0);
    go(0);
    wan_alarm_en = 1;
    tick(3);
    chk("alarm lan", 0, wan_alarm_r);
    port_is_wan10g = 1;
    tick(3);
    chk("alarm wan", 1, wan_alarm_r);
    wan_err_mode = 1;
    w0 = wn;
    wan_trigger = 1;
    tick(1);
    wan_trigger = 0;
    send(6);
    tick(3);
    chk("wan errors", 2, wn - w0);
    rate(16'h0, c0);
    chk("nominal ticks", 512, c0);
    rate(16'h7FFF, c0);
    rate(16'h8000, c1);
    chk("deviation order", 1, c0 > 512 && c1 < 512);
    results;
  end
  initial begin
    repeat (12000) @(posedge core_clk);
    n_fail++;
    results;
  end
endmodule // pesi_injector_bench

// >>> test/pesi_props.sv
// Purpose: port checks for the pcs error and skew injector
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the injector below
`timescale 1ns/1ns
module pesi_props #(parameter LANES = 4, parameter BLK_W = 66, parameter SKEW_W = 7) (
  // watched ports
  input logic core_clk, resetn, blk_valid, err_alarm_sel, port_is_wan10g,
  input logic wan_alarm_en, wan_alarm_r, tx_rate_tick_r,
  input logic [LANES*BLK_W-1:0] blk_data, out_data_r,
  input logic [1:0] err_dest,
  input logic [2:0] ins_mode,
  input logic [LANES-1:0] err_lane_mask,
  input logic [SKEW_W-1:0] skew_bits,
  input logic [15:0] tx_deviation
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // two blocks so the new mode is latched before the checked one
  sequence all_s(d);
    (blk_valid && ins_mode == 3'h5 && err_dest == d && !err_alarm_sel && skew_bits == 0)[*2];
  endsequence
  off_clean_a: assert property ((blk_valid && ins_mode == 3'h0 && skew_bits == 0)[*2]
    |=> out_data_r == $past(blk_data)) else $error("data altered in off mode");
  all_sync_a: assert property (all_s(2'h1) ##0 err_lane_mask[0] |=> out_data_r[1:0] == 2'h3)
    else $error("sync header not corrupted");
  all_type_a: assert property (all_s(2'h0) ##0 err_lane_mask[0] |=> out_data_r[9:2] == 8'h00)
    else $error("block type not corrupted");
  lane_mask_a: assert property (all_s(2'h1) ##0 !err_lane_mask[3]
    |=> out_data_r[263:198] == $past(blk_data[263:198])) else $error("unselected lane altered");
  wan_gate_a: assert property ((!port_is_wan10g)[*2] |-> !wan_alarm_r)
    else $error("wan alarm outside wan port");
  alarm_hold_a: assert property ((port_is_wan10g && wan_alarm_en)[*2] |-> wan_alarm_r)
    else $error("wan alarm not held");
  alarm_off_a: assert property ((!wan_alarm_en)[*2] |-> !wan_alarm_r)
    else $error("wan alarm while disabled");
  tick_period_a: assert property (tx_rate_tick_r && tx_deviation == 0 && $past(tx_deviation) == 0
    |=> !tx_rate_tick_r[*3] ##1 tx_rate_tick_r) else $error("nominal tick period wrong");
endmodule // pesi_props
bind pesi_injector pesi_props #(.LANES(LANES), .BLK_W(BLK_W), .SKEW_W(SKEW_W)) chk_i(.*);

// >>> test/pesi_rx_model.sv
// Purpose: far-end pcs receiver counting undefined blocks
// Assumes: four lanes, lanes 0 and 3 watched
// Notes: behavioural only
`timescale 1ns/1ns
module pesi_rx_model (
  input wire core_clk,
  input wire vld,
  input wire [263:0] data,
  output reg [15:0] bad0 = 0,
  output reg [15:0] bad3 = 0
);
  function bad(input [65:0] b);
    bad = b[1:0] == 2'h0 || b[1:0] == 2'h3 || (b[1:0] == 2'h2 && b[9:2] == 8'h00);
  endfunction
  always @(posedge core_clk) begin
    if (vld) begin
      bad0 <= bad0 + bad(data[65:0]);
      bad3 <= bad3 + bad(data[263:198]);
    end
  end
endmodule // pesi_rx_model
